// ===== hw/ipc_ctrl.sv
// ============================================================
// Interrupt priority control word with APB slave
// ============================================================
// Four slots, each with a priority and a subpriority field.
// Assumes an APB master on clk_i and a synchronous reset.
//
// Function
// - Priority zero disables the slot; it is never presented for service.
// - Nonzero priority one to seven is the level, seven highest.
// - Each slot has a two-bit subpriority, zero to three.
// - Priority fields at bits 28:26, 20:18, 12:10, 4:2.
// - Subpriority fields at bits 25:24, 17:16, 9:8, 1:0.
// - Top three bits of every byte ignore writes and read zero.
//
// The bus answers every transfer one cycle after its setup phase, with no
// wait states; a write lands at the edge that closes the access phase.
// A read-only summary word reports which slots are enabled.
module ipc_ctrl
    import ipc_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [11:0]           paddr_i,
    input  wire logic [31:0]           pwdata_i,
    input  wire logic [3:0]            pstrb_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    output ipc_service_t [IPC_SLOTS-1:0] service_o,
    output logic      [IPC_SLOTS-1:0]  enabled_o
);

    // ========================================================
    // Slot storage
    // ========================================================
    // Stored fields and their next values
    ipc_slot_t [IPC_SLOTS-1:0] slot;
    ipc_slot_t [IPC_SLOTS-1:0] next_slot;
    ipc_service_t [IPC_SLOTS-1:0] next_service;
    logic [IPC_SLOTS-1:0]      next_enabled;
    logic [31:0]               next_prdata;
    logic                      next_pready;
    logic                      next_pslverr;
    // Bus decode
    logic                      setup;
    logic                      access_wr;
    logic                      hit_word;
    logic                      hit_sum;

    // ========================================================
    // Elaboration checks
    // ========================================================
    // The slots must fit the word and each field must fit its byte
    if (IPC_SLOTS * IPC_SLOT_STEP > 32) begin : g_bad_slots
        $error("Slot count does not fit the control word");
    end
    if (IPC_PRIO_LSB + IPC_PRIO_W > IPC_SLOT_STEP - 3) begin : g_bad_prio
        $error("Priority field reaches the unimplemented bits");
    end
    if (IPC_SUB_LSB + IPC_SUB_W > IPC_PRIO_LSB) begin : g_bad_sub
        $error("Subpriority field overlaps the priority field");
    end

    // Setup phase; the answer comes in the following access cycle
    assign setup     = psel_i && !penable_i;
    // A write lands only at the edge that closes the access phase, so a
    // transfer abandoned before pready never alters a slot
    assign access_wr = psel_i && penable_i && pready_o && pwrite_i;
    assign hit_word  = paddr_i == IPC_OFF_PRIORITY_CONTROL_WORD;
    assign hit_sum   = paddr_i == IPC_OFF_PRIORITY_SUMMARY;

    // Field writes, byte lanes honoured; only implemented bits kept.
    // A lane whose strobe is low keeps its slot as it was.
    always_comb begin
        next_slot = slot;
        for (int i = 0; i < IPC_SLOTS; i++) begin
            if (access_wr && hit_word && pstrb_i[i]) begin
                next_slot[i].priority_level =
                    pwdata_i[i*IPC_SLOT_STEP+IPC_PRIO_LSB +: IPC_PRIO_W];
                next_slot[i].subpriority =
                    pwdata_i[i*IPC_SLOT_STEP+IPC_SUB_LSB +: IPC_SUB_W];
            end
        end
    end

    // Reset clears every field
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < IPC_SLOTS; i++) begin
                slot[i].priority_level <= IPC_PRIO_RESET;
                slot[i].subpriority    <= IPC_SUB_RESET;
            end
        end else begin
            slot <= next_slot;
        end
    end

    // ========================================================
    // Service view per slot
    // ========================================================
    // Views are built from the next values, so they change on the same
    // edge as the stored fields and never lag a write by a cycle
    genvar g;
    generate
        for (g = 0; g < IPC_SLOTS; g++) begin : g_service
            assign next_enabled[g] = next_slot[g].priority_level != IPC_PRIO_OFF;
            assign next_service[g].enabled = next_enabled[g];
            assign next_service[g].level = next_slot[g].priority_level;
            assign next_service[g].sublevel = next_slot[g].subpriority;
        end
    endgenerate

    // Outputs follow the stored word in the same cycle it updates
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            service_o <= '0;
            enabled_o <= '0;
        end else begin
            service_o <= next_service;
            enabled_o <= next_enabled;
        end
    end

    // ========================================================
    // APB read path and answer
    // ========================================================
    // Every transfer is answered one cycle after setup, with no wait states;
    // unimplemented bits keep the zero default on every path
    always_comb begin
        next_prdata  = IPC_READ_ZERO;
        next_pready  = setup;
        next_pslverr = setup && !(hit_word || hit_sum);
        if (setup && !pwrite_i && hit_word) begin
            for (int i = 0; i < IPC_SLOTS; i++) begin
                next_prdata[i*IPC_SLOT_STEP+IPC_PRIO_LSB +: IPC_PRIO_W] =
                    slot[i].priority_level;
                next_prdata[i*IPC_SLOT_STEP+IPC_SUB_LSB +: IPC_SUB_W] =
                    slot[i].subpriority;
            end
        end else if (setup && !pwrite_i && hit_sum) begin
            next_prdata[IPC_SLOTS-1:0] = enabled_o; // Enabled slot summary
        end
    end

    // Answer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_o  <= IPC_READ_ZERO;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    generate
        for (g = 0; g < IPC_SLOTS; g++) begin : g_chk
            // Output enable flag follows the stored priority
            a_slot_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
                enabled_o[g] == (slot[g].priority_level != IPC_PRIO_OFF))
                else $error("Slot enable does not match priority");
            // Service view repeats the same enable flag
            a_view_enable: assert property (@(posedge clk_i) disable iff (rst_i)
                service_o[g].enabled == enabled_o[g])
                else $error("Service enable differs from enable output");
            // Level and subpriority pass through unchanged
            a_level_passes: assert property (@(posedge clk_i) disable iff (rst_i)
                service_o[g].level == slot[g].priority_level)
                else $error("Service level differs from stored priority");
            a_sub_passes: assert property (@(posedge clk_i) disable iff (rst_i)
                service_o[g].sublevel == slot[g].subpriority)
                else $error("Service sublevel differs from stored subpriority");
            // A completed write leaves a slot alone unless its lane is strobed
            a_lane_kept: assert property (@(posedge clk_i) disable iff (rst_i)
                access_wr && !(hit_word && pstrb_i[g]) |=> slot[g] == $past(slot[g]))
                else $error("Slot changed without a strobed write");
        end
    endgenerate

    // Written fields land at the edge that closes the access phase
    a_write_prio: assert property (@(posedge clk_i) disable iff (rst_i)
        access_wr && hit_word && pstrb_i[3]
        |=> slot[3].priority_level == $past(pwdata_i[28:26]))
        else $error("Slot three priority not taken from bits 28:26");
    a_write_sub: assert property (@(posedge clk_i) disable iff (rst_i)
        access_wr && hit_word && pstrb_i[2]
        |=> slot[2].subpriority == $past(pwdata_i[17:16]))
        else $error("Slot two subpriority not taken from bits 17:16");
    // Read data carries each slot's fields at their byte positions
    a_read_prio: assert property (@(posedge clk_i) disable iff (rst_i)
        setup && !pwrite_i && hit_word |=> prdata_o[28:26] == $past(slot[3].priority_level))
        else $error("Slot three priority not read at bits 28:26");
    a_read_sub: assert property (@(posedge clk_i) disable iff (rst_i)
        setup && !pwrite_i && hit_word |=> prdata_o[1:0] == $past(slot[0].subpriority))
        else $error("Slot zero subpriority not read at bits 1:0");
    // Summary read reports one enable bit per slot
    a_sum_read: assert property (@(posedge clk_i) disable iff (rst_i)
        setup && !pwrite_i && hit_sum |=> prdata_o[IPC_SLOTS-1:0] == $past(enabled_o))
        else $error("Summary read differs from slot enables");
    // Unimplemented bits never read as one
    a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        pready_o |-> (prdata_o & 32'hE0E0_E0E0) == 32'h0000_0000)
        else $error("Unimplemented bits read nonzero");
    // Reset clears the stored fields and both views
    a_reset_clear: assert property (@(posedge clk_i)
        rst_i |=> enabled_o == '0 && service_o == '0 && slot == '0)
        else $error("Slots not cleared by reset");
    // An unmapped address is answered with an error
    a_bad_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        setup && !(hit_word || hit_sum) |=> pready_o && pslverr_o)
        else $error("Unmapped address not answered with an error");
    // One answer pulse per setup phase
    a_ready_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        setup |=> pready_o ##1 !pready_o)
        else $error("Answer not a single cycle after setup");

endmodule // ipc_ctrl

// ===== hw/ipc_pkg.sv
// ============================================================
// Package for the interrupt priority control word
// ============================================================
// Holds offsets, field positions, reset values and slot types.
// Assumes a single 250 MHz clock domain with APB access.
package ipc_pkg;

    // ========================================================
    // Register map
    // ========================================================
    localparam logic [11:0] IPC_OFF_PRIORITY_CONTROL_WORD = 12'h000;
    localparam logic [11:0] IPC_OFF_PRIORITY_SUMMARY      = 12'h004;

    // ========================================================
    // Field layout within each byte of the control word
    // ========================================================
    localparam int IPC_SLOTS     = 4;
    localparam int IPC_PRIO_LSB  = 2;
    localparam int IPC_PRIO_W    = 3;
    localparam int IPC_SUB_LSB   = 0;
    localparam int IPC_SUB_W     = 2;
    localparam int IPC_SLOT_STEP = 8;

    // ========================================================
    // Reset values
    // ========================================================
    localparam logic [2:0]  IPC_PRIO_RESET = 3'h0;
    localparam logic [1:0]  IPC_SUB_RESET  = 2'h0;
    localparam logic [2:0]  IPC_PRIO_OFF   = 3'h0;
    localparam logic [31:0] IPC_READ_ZERO  = 32'h0000_0000;

    // One slot's settings
    typedef struct packed {
        logic [2:0] priority_level;
        logic [1:0] subpriority;
    } ipc_slot_t;

    // One slot's service view, as presented to the arbiter
    typedef struct packed {
        logic       enabled;
        logic [2:0] level;
        logic [1:0] sublevel;
    } ipc_service_t;

endpackage : ipc_pkg

// ===== verification/test_interrupt_priority_control.sv
// ============================================================
// Testbench for the interrupt priority control word.
// ============================================================
// Assumes ipc_pkg and ipc_ctrl are compiled first; drives APB directly.
module test_interrupt_priority_control
    import ipc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================
    // Signals, clock and instance
    // ========================================================
    logic                          clk_i = 1'b0, rst_i = 1'b1;
    logic                          psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0]                   paddr_i = 12'h000;
    logic [31:0]                   pwdata_i = 32'h0000_0000, rd;
    logic [3:0]                    pstrb_i = 4'h0;
    logic [31:0]                   prdata_o;
    logic                          pready_o, pslverr_o, err;
    ipc_service_t [IPC_SLOTS-1:0]  service_o;
    logic [IPC_SLOTS-1:0]          enabled_o;
    int                            n_fail = 0, n_checks = 0;
    always #2 clk_i = ~clk_i; // 250 MHz
    ipc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .service_o(service_o), .enabled_o(enabled_o));
    // ========================================================
    // Shared tasks
    // ========================================================
    // Compares one value and counts the outcome
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
        paddr_i <= a; pwdata_i <= d; pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0000_0001, 32'h0000_0000);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask
    // Expected service view worked out from a stored word
    function automatic logic [31:0] svc(input logic [31:0] w);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 4; i++) r[6*i+:6] = {w[8*i+2+:3] != 3'h0, w[8*i+:5]};
        return r;
    endfunction
    // Reads the word back and checks both slot outputs against it
    task automatic expect_word(input logic [31:0] w);
        logic [31:0] s;
        s = svc(w);
        apb(1'b0, IPC_OFF_PRIORITY_CONTROL_WORD, 32'h0000_0000, 4'hF);
        chk(rd, w);
        chk({31'h0, err}, 32'h0000_0000);
        chk({8'h00, service_o}, s);
        chk({28'h0, enabled_o}, {28'h0, s[23], s[17], s[11], s[5]});
    endtask
    // ========================================================
    // Scenarios
    // ========================================================
    // Mapped fields and the unimplemented top bits of each byte
    task automatic t_fields;
        expect_word(32'h0000_0000);
        apb(1'b1, IPC_OFF_PRIORITY_CONTROL_WORD, 32'hFFFF_FFFF, 4'hF);
        expect_word(32'h1F1F_1F1F);
        apb(1'b1, IPC_OFF_PRIORITY_CONTROL_WORD, 32'hFBEE_E7E0, 4'hF);
        expect_word(32'h1B0E_0700);
        chk({8'h00, service_o}, {8'h00, 6'b111011, 6'b101110, 6'b100111, 6'b000000});
        apb(1'b0, IPC_OFF_PRIORITY_SUMMARY, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_000E);
    endtask
    // Every priority code and subpriority code in all slots
    task automatic t_levels;
        logic [7:0] b;
        for (int p = 0; p < 8; p++) begin
            b = {3'b000, p[2:0], p[1:0]};
            apb(1'b1, IPC_OFF_PRIORITY_CONTROL_WORD, {4{b}}, 4'hF);
            expect_word({4{b}});
            chk({29'h0, service_o[3].level}, p);
        end
    endtask
    // Lane strobes, unmapped address and a reset in mid-run
    task automatic t_lanes_reset;
        apb(1'b1, IPC_OFF_PRIORITY_CONTROL_WORD, 32'h0000_0000, 4'h2);
        expect_word(32'h1F1F_001F);
        apb(1'b1, 12'h008, 32'h0000_0000, 4'hF);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        expect_word(32'h1F1F_001F);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        expect_word(32'h0000_0000);
    endtask
    // ========================================================
    // Sequence, watchdog and verdict
    // ========================================================
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_fields;
        t_levels;
        t_lanes_reset;
        wrap_up;
    end
    initial begin
        #20000;
        n_fail++;
        wrap_up;
    end
endmodule // test_interrupt_priority_control
